// file: stack_unit_pkg.sv
`default_nettype none
package stack_unit_pkg;
  // stack operation commands
  typedef enum logic [3:0] {
    OP_NONE,
    OP_PUSH_SEL,
    OP_POP_SEL,
    OP_PUSH_ERR,
    OP_FAR_CALL,
    OP_RET_GATE16,
    OP_POP_MEM,
    OP_WRITE_CTRL
  } stack_op_t;

  localparam int SELECTOR_BYTES = 2;
  localparam int ERROR_CODE_BYTES = 4;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int PAGING_BIT = 31;
  localparam logic [15:0] LIMIT16_MAX = 16'hFFFF;
  localparam int DESC_LIMIT_LO = 0;
  localparam int DESC_BASE_LO = 16;
  localparam int DESC_RSVD_WORD = 48;
  localparam int DESC_SIZE_FLAG = 54;
  localparam int DESC_GRAN_FLAG = 55;
  localparam int DESC_LIMIT_HI = 48;
  localparam int DESC_BASE_HI = 56;
  localparam int SERIALIZE_CYCLES = 2;
endpackage : stack_unit_pkg
`default_nettype wire

// file: mem_port_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mem_port_if;
  logic req;
  logic wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [3:0] byteEn;
  logic done;
  logic fault;
  logic [31:0] rdata;
  modport master(output req, wr, addr, wdata, byteEn, input done, fault, rdata);
  modport slave(input req, wr, addr, wdata, byteEn, output done, fault, rdata);
endinterface : mem_port_if
`default_nettype wire

// file: descriptor_decode.sv
`timescale 1ns/1ns
`default_nettype none
module descriptor_decode
  import stack_unit_pkg::*;
(
  input wire logic [63:0] desc, // raw descriptor
  output logic [31:0] base, // linear base
  output logic [31:0] limitBytes, // limit in bytes
  output logic bigFlag // 32-bit size flag
);
  logic legacy;
  logic [19:0] rawLimit;
  assign legacy = (desc[DESC_RSVD_WORD +: 16] == 16'h0000);
  assign rawLimit = {desc[DESC_LIMIT_HI +: 4], desc[DESC_LIMIT_LO +: 16]};
  assign base = legacy ? {8'h00, desc[DESC_BASE_LO +: 24]}
                       : {desc[DESC_BASE_HI +: 8], desc[DESC_BASE_LO +: 24]};
  assign limitBytes = legacy ? {16'h0000, desc[DESC_LIMIT_LO +: 16]}
                    : desc[DESC_GRAN_FLAG] ? {rawLimit, 12'hFFF} : {12'h000, rawLimit};
  assign bigFlag = legacy ? 1'b0 : desc[DESC_SIZE_FLAG];
endmodule : descriptor_decode
`default_nettype wire

// file: legacy_stack_descriptor_unit.sv
`timescale 1ns/1ns
`default_nettype none
module legacy_stack_descriptor_unit
  import stack_unit_pkg::*;
#(
  parameter bit ALT_VARIANT = 1'b0 // alternative selector access variant
)(
  input wire logic sys_clk, // core clock
  input wire logic rst, // async reset, high
  input wire logic clkEn, // freezes all state when low
  input wire stack_op_t opCode, // operation
  input wire logic opStart, // start pulse
  input wire logic opSize32, // 32-bit operand size
  input wire logic [31:0] opData, // selector, error code, control value
  input wire logic [31:0] memOffset, // scaled index plus displacement
  input wire logic targetOk, // far call target check result
  input wire logic [63:0] ssDesc, // stack descriptor
  input wire logic [63:0] csDesc, // code or data descriptor
  input wire logic sysDesc32, // system descriptor is 32-bit form
  input wire logic memDone, // memory done
  input wire logic memFault, // memory fault
  input wire logic [31:0] memRdata, // memory read data
  output logic memReq, // memory request
  output logic memWr, // write when high
  output logic [31:0] memAddr, // stack offset
  output logic [31:0] memWdata, // write data
  output logic [3:0] memByteEn, // byte enables
  output logic [31:0] stack_pointer, // full pointer
  output logic [15:0] selOut, // popped selector
  output logic selValid, // selector pulse
  output logic paging_on_flag, // paging enabled
  output logic [31:0] control_word_zero, // control register
  output logic busy, // operation in flight
  output logic opFault, // fault pulse
  output logic [31:0] ssBase, // stack base
  output logic [31:0] ssLimit, // stack limit
  output logic code32, // code/data 32-bit
  output logic gate32 // system descriptor 32-bit
);
  // ****************************************
  // descriptors and memory carrier
  // ****************************************
  typedef enum {S_IDLE, S_CHECK, S_MEM, S_SERIAL} state_t;
  state_t state;
  mem_port_if mp();
  logic stack32;
  logic [31:0] csBase;
  logic [31:0] csLimit;
  logic [31:0] savedSp;
  stack_op_t curOp;
  logic curSize32;
  logic [31:0] curData;
  logic [31:0] curOffset;
  logic [1:0] serialCnt;
  logic [1:0] callPush;

  descriptor_decode ssDec (
    .desc(ssDesc),
    .base(ssBase),
    .limitBytes(ssLimit),
    .bigFlag(stack32)
  );
  descriptor_decode csDec (
    .desc(csDesc),
    .base(csBase),
    .limitBytes(csLimit),
    .bigFlag(code32)
  );
  assign gate32 = sysDesc32;

  assign mp.done = memDone;
  assign mp.fault = memFault;
  assign mp.rdata = memRdata;
  assign memReq = mp.req;
  assign memWr = mp.wr;
  assign memAddr = mp.addr;
  assign memWdata = mp.wdata;
  assign memByteEn = mp.byteEn;
  assign busy = (state != S_IDLE);

  // ****************************************
  // pointer arithmetic
  // ****************************************
  function automatic logic [31:0] moveSp(input logic [31:0] sp, input logic [31:0] delta,
                                         input logic big);
    logic [15:0] low;
    low = sp[15:0] + delta[15:0];
    moveSp = big ? sp + delta : {sp[31:16], low};
  endfunction : moveSp

  function automatic logic [31:0] slotAddr(input logic [31:0] sp, input logic big);
    slotAddr = big ? sp : {16'h0000, sp[15:0]};
  endfunction : slotAddr

  logic [31:0] opStep;
  assign opStep = curSize32 ? 32'h0000_0004 : 32'h0000_0002;

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      curOp <= OP_NONE;
      curSize32 <= 1'b0;
      curData <= 32'h0000_0000;
      curOffset <= 32'h0000_0000;
      savedSp <= SP_RESET;
      stack_pointer <= SP_RESET;
      serialCnt <= 2'h0;
      callPush <= 2'h0;
      mp.req <= 1'b0;
      mp.wr <= 1'b0;
      mp.addr <= 32'h0000_0000;
      mp.wdata <= 32'h0000_0000;
      mp.byteEn <= 4'h0;
      selOut <= 16'h0000;
      selValid <= 1'b0;
      opFault <= 1'b0;
    end else if (clkEn) begin
      selValid <= 1'b0;
      opFault <= 1'b0;
      case (state)
        S_IDLE: begin
          if (opStart) begin
            curOp <= opCode;
            curSize32 <= opSize32;
            curData <= opData;
            curOffset <= memOffset;
            savedSp <= stack_pointer;
            state <= S_CHECK;
          end
        end
        S_CHECK: begin
          state <= S_MEM;
          mp.req <= 1'b1;
          case (curOp)
            OP_PUSH_SEL: begin
              stack_pointer <= moveSp(stack_pointer, -opStep, stack32);
              mp.addr <= slotAddr(moveSp(stack_pointer, -opStep, stack32), stack32);
              mp.wr <= 1'b1;
              mp.wdata <= {16'h0000, curData[15:0]};
              mp.byteEn <= (ALT_VARIANT && curSize32) ? 4'hF : 4'h3;
            end
            OP_POP_SEL, OP_RET_GATE16: begin
              mp.addr <= slotAddr(stack_pointer, stack32);
              mp.wr <= 1'b0;
              mp.byteEn <= (ALT_VARIANT && curSize32 && curOp == OP_POP_SEL) ? 4'hF : 4'h3;
            end
            OP_POP_MEM: begin
              // read source slot first
              mp.addr <= slotAddr(stack_pointer, stack32);
              mp.wr <= 1'b0;
              mp.byteEn <= curSize32 ? 4'hF : 4'h3;
            end
            OP_PUSH_ERR: begin
              stack_pointer <= moveSp(stack_pointer, 32'hFFFF_FFFC, stack32);
              mp.addr <= slotAddr(moveSp(stack_pointer, 32'hFFFF_FFFC, stack32), stack32);
              mp.wr <= 1'b1;
              mp.wdata <= {16'h0000, curData[15:0]};
              mp.byteEn <= 4'hF;
            end
            OP_FAR_CALL: begin
              if (!targetOk) begin
                mp.req <= 1'b0;
                opFault <= 1'b1;
                state <= S_IDLE;
              end else begin
                callPush <= 2'h2;
                stack_pointer <= moveSp(stack_pointer, -opStep, stack32);
                mp.addr <= slotAddr(moveSp(stack_pointer, -opStep, stack32), stack32);
                mp.wr <= 1'b1;
                mp.wdata <= curData;
                mp.byteEn <= curSize32 ? 4'hF : 4'h3;
              end
            end
            OP_WRITE_CTRL: begin
              mp.req <= 1'b0;
              serialCnt <= 2'(SERIALIZE_CYCLES - 1);
              state <= S_SERIAL;
            end
            default: begin
              mp.req <= 1'b0;
              state <= S_IDLE;
            end
          endcase
        end
        S_MEM: begin
          if (mp.fault) begin
            stack_pointer <= savedSp;
            mp.req <= 1'b0;
            opFault <= 1'b1;
            state <= S_IDLE;
          end else if (mp.done) begin
            mp.req <= 1'b0;
            state <= S_IDLE;
            case (curOp)
              OP_POP_SEL: begin
                selOut <= mp.rdata[15:0];
                selValid <= 1'b1;
                stack_pointer <= moveSp(stack_pointer, opStep, stack32);
              end
              OP_RET_GATE16: begin
                stack_pointer <= {16'h0000, mp.rdata[15:0]};
              end
              OP_POP_MEM: begin
                if (!mp.wr) begin
                  stack_pointer <= moveSp(stack_pointer, opStep, stack32);
                  mp.req <= 1'b1;
                  mp.wr <= 1'b1;
                  mp.wdata <= mp.rdata;
                  mp.addr <= slotAddr(moveSp(stack_pointer, opStep, stack32), stack32)
                             + curOffset;
                  state <= S_MEM;
                end
              end
              OP_FAR_CALL: begin
                if (callPush == 2'h2) begin
                  callPush <= 2'h1;
                  stack_pointer <= moveSp(stack_pointer, -opStep, stack32);
                  mp.addr <= slotAddr(moveSp(stack_pointer, -opStep, stack32), stack32);
                  mp.wdata <= {16'h0000, curData[15:0]};
                  mp.req <= 1'b1;
                  state <= S_MEM;
                end
              end
              default: begin
              end
            endcase
          end
        end
        S_SERIAL: begin
          if (serialCnt == 2'h0) begin
            state <= S_IDLE;
          end else begin
            serialCnt <= serialCnt - 2'h1;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_word_zero <= CTRL_RESET;
    end else if (clkEn && state == S_CHECK && curOp == OP_WRITE_CTRL) begin
      control_word_zero <= curData;
    end
  end
  assign paging_on_flag = control_word_zero[PAGING_BIT];

  // ****************************************
  // checks
  // ****************************************
  logic [31:0] pastSp;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pastSp <= SP_RESET;
    end else if (clkEn && state == S_IDLE) begin
      pastSp <= stack_pointer;
    end
  end

  AST_PUSH_BYTES: assert property (@(posedge sys_clk) disable iff (rst)
    (mp.req && mp.wr && curOp == OP_PUSH_SEL && !ALT_VARIANT) |-> mp.byteEn == 4'h3)
    else $error("selector push touched upper bytes");
  AST_PUSH_DEC: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && state == S_CHECK && curOp == OP_PUSH_SEL && stack32) |=>
    stack_pointer == $past(stack_pointer) - $past(opStep))
    else $error("push did not drop pointer");
  AST_POP_LOADFIRST: assert property (@(posedge sys_clk) disable iff (rst)
    (state == S_MEM && curOp == OP_POP_SEL) |-> stack_pointer == pastSp)
    else $error("pointer moved before pop load");
  AST_ERR_WORD: assert property (@(posedge sys_clk) disable iff (rst)
    (mp.req && curOp == OP_PUSH_ERR) |-> (mp.byteEn == 4'hF && mp.wdata[31:16] == 16'h0000))
    else $error("error code not full word");
  AST_CALL_NOWRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && state == S_CHECK && curOp == OP_FAR_CALL && !targetOk) |=> !mp.req)
    else $error("push after failed target check");
  AST_FAULT_RESTORE: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && state == S_MEM && mp.fault) |=> stack_pointer == pastSp)
    else $error("pointer not restored on fault");
  AST_RET_UPPER: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && state == S_MEM && curOp == OP_RET_GATE16 && mp.done && !mp.fault) |=>
    stack_pointer[31:16] == 16'h0000)
    else $error("upper pointer half not zero");
  AST_SP16: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && !stack32 && curOp != OP_RET_GATE16 && !(state == S_MEM && mp.fault)) |=>
    stack_pointer[31:16] == $past(stack_pointer[31:16]))
    else $error("16-bit stack moved upper half");
  AST_LEGACY_BASE: assert property (@(posedge sys_clk) disable iff (rst)
    (ssDesc[63:48] == 16'h0000) |-> (ssBase[31:24] == 8'h00 && ssLimit[31:16] == 16'h0000))
    else $error("legacy descriptor widened");
  AST_SERIAL: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && state == S_CHECK && curOp == OP_WRITE_CTRL) |=> busy)
    else $error("control write not serializing");

  COV_PUSH: cover property (@(posedge sys_clk) disable iff (rst)
    mp.req && mp.done && curOp == OP_PUSH_SEL);
  COV_POP: cover property (@(posedge sys_clk) disable iff (rst) selValid);
  COV_FAULT: cover property (@(posedge sys_clk) disable iff (rst) opFault);
  COV_PAGING: cover property (@(posedge sys_clk) disable iff (rst) $rose(paging_on_flag));
endmodule : legacy_stack_descriptor_unit
`default_nettype wire

// file: stack_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************
// far-side stack memory
// ****************************
module stack_mem_model (
  input wire logic sys_clk, // core clock
  input wire logic rst, // async reset
  input wire logic slow, // stretch answers
  input wire logic failNext, // answer with fault
  input wire logic req, // request
  input wire logic wr, // write
  input wire logic [31:0] addr, // stack offset
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] byteEn, // byte enables
  output logic done, // done pulse
  output logic fault, // fault pulse
  output logic [31:0] rdata, // read data
  output logic [31:0] lastAddr, // last write offset
  output logic [31:0] lastData, // last write data
  output logic [3:0] lastBe // last write enables
);
  logic [7:0] mem [logic [31:0]];
  logic [3:0] waitCnt;
  function automatic logic [7:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction : rd
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
      fault <= 1'b0;
      rdata <= 32'h0;
      waitCnt <= 4'h0;
    end else begin
      done <= 1'b0;
      fault <= 1'b0;
      // idle bus never keeps the last answer
      rdata <= ~rdata;
      if (req && !done && !fault) begin
        if (waitCnt < (slow ? 4'h5 : 4'h0)) begin
          waitCnt <= waitCnt + 4'h1;
        end else if (failNext) begin
          waitCnt <= 4'h0;
          fault <= 1'b1;
        end else begin
          waitCnt <= 4'h0;
          done <= 1'b1;
          rdata <= {rd(addr + 32'h3), rd(addr + 32'h2), rd(addr + 32'h1), rd(addr)};
          if (wr) begin
            lastAddr <= addr;
            lastData <= wdata;
            lastBe <= byteEn;
            for (int i = 0; i < 4; i++) begin
              if (byteEn[i]) mem[addr + 32'(i)] = wdata[8*i +: 8];
            end
          end
        end
      end
    end
  end
endmodule : stack_mem_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import stack_unit_pkg::*;
;
  logic sys_clk, rst, clkEn, opStart, opSize32, targetOk, sysDesc32, memDone, memFault;
  logic memReq, memWr, selValid, paging_on_flag, busy, opFault, code32, gate32;
  logic slow, failNext, sawFault, sawReq, big, s32;
  stack_op_t opCode;
  logic [31:0] opData, memOffset, memRdata, memAddr, memWdata, stack_pointer, control_word_zero;
  logic [31:0] ssBase, ssLimit, lastAddr, lastData, rng, sp, d, prevAddr;
  logic [63:0] ssDesc, csDesc;
  logic [3:0] memByteEn, lastBe;
  logic [15:0] selOut, selSeen;
  logic [15:0] selQ[$];
  int err_total, checks_done, cycles, busyCycles;
  legacy_stack_descriptor_unit uut (.sys_clk, .rst, .clkEn, .opCode, .opStart, .opSize32,
    .opData, .memOffset, .targetOk, .ssDesc, .csDesc, .sysDesc32, .memDone, .memFault,
    .memRdata, .memReq, .memWr, .memAddr, .memWdata, .memByteEn, .stack_pointer, .selOut,
    .selValid, .paging_on_flag, .control_word_zero, .busy, .opFault, .ssBase, .ssLimit,
    .code32, .gate32);
  stack_mem_model memModel (.sys_clk, .rst, .slow, .failNext, .req(memReq), .wr(memWr),
    .addr(memAddr), .wdata(memWdata), .byteEn(memByteEn), .done(memDone), .fault(memFault),
    .rdata(memRdata), .lastAddr, .lastData, .lastBe);
  // ****************************
  // clock and watchdog
  // ****************************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // ****************************
  // helpers
  // ****************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // 16-bit stack moves only the low half
  function automatic logic [31:0] bump(input logic [31:0] v, input logic [31:0] dv, input logic b);
    return b ? v + dv : {v[31:16], v[15:0] + dv[15:0]};
  endfunction : bump
  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic runOp(input stack_op_t op, input logic z, input logic [31:0] v);
    @(posedge sys_clk);
    opCode <= op;
    opSize32 <= z;
    opData <= v;
    opStart <= 1'b1;
    sawFault = 1'b0;
    sawReq = 1'b0;
    @(posedge sys_clk);
    opStart <= 1'b0;
    #1;
    busyCycles = 0;
    while (busy !== 1'b0 && busyCycles < 300) begin
      @(posedge sys_clk);
      #1;
      busyCycles++;
      // pulses stand one cycle and end with busy: catch them here
      if (opFault === 1'b1) sawFault = 1'b1;
      if (memReq === 1'b1) sawReq = 1'b1;
      if (selValid === 1'b1) selSeen = selOut;
    end
    chk(busy, 1'b0, "op never ended");
  endtask : runOp
  // ****************************
  // main sequence
  // ****************************
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    opStart = 1'b0;
    opCode = OP_NONE;
    opSize32 = 1'b0;
    opData = 32'h0;
    memOffset = 32'h0;
    targetOk = 1'b1;
    ssDesc = 64'h0;
    csDesc = 64'h0;
    sysDesc32 = 1'b0;
    slow = 1'b0;
    failNext = 1'b0;
    rng = 32'h36;
    sp = SP_RESET;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk(stack_pointer, SP_RESET, "reset pointer");
    chk(control_word_zero, CTRL_RESET, "reset control");
    $display("test reset done");
    // 16-bit stack first so the upper pointer half stays known
    for (int k = 0; k < 4; k++) begin
      big = k[1];
      s32 = k[0];
      ssDesc <= {9'h0, big, 54'h0};
      slow <= k[0];
      rng = xs(rng);
      d = rng;
      selQ.push_back(d[15:0]);
      runOp(OP_PUSH_SEL, s32, d);
      sp = bump(sp, s32 ? 32'hFFFF_FFFC : 32'hFFFF_FFFE, big);
      chk(stack_pointer, sp, "push pointer");
      chk(lastAddr, sp, "push offset");
      chk(32'(lastBe), 32'h3, "push enables");
      chk(32'(lastData[15:0]), 32'(d[15:0]), "push selector");
      runOp(OP_POP_SEL, s32, 32'h0);
      sp = bump(sp, s32 ? 32'h4 : 32'h2, big);
      chk(32'(selSeen), 32'(selQ.pop_back()), "popped selector");
      chk(stack_pointer, sp, "pop pointer");
    end
    $display("test selectors done");
    rng = xs(rng);
    d = {rng[31:16], 16'hFFFC};
    runOp(OP_PUSH_ERR, 1'b1, d);
    sp = sp - 32'h4;
    chk(stack_pointer, sp, "error pointer");
    chk(32'(lastBe), 32'hF, "error enables");
    chk(lastData, {16'h0, d[15:0]}, "error word");
    runOp(OP_RET_GATE16, 1'b0, 32'h0);
    sp = {16'h0, d[15:0]};
    chk(stack_pointer, sp, "gate return pointer");
    ssDesc <= 64'h0;
    memOffset <= rng & 32'h0000_0FF0;
    runOp(OP_POP_MEM, 1'b1, 32'h0);
    sp = 32'h0;
    chk(stack_pointer, sp, "wrap pointer");
    chk(lastAddr, memOffset, "wrap destination");
    $display("test error push and wrap done");
    targetOk <= 1'b0;
    prevAddr = lastAddr;
    runOp(OP_FAR_CALL, 1'b1, rng);
    chk(32'({sawFault, sawReq}), 32'h2, "refused call");
    chk(stack_pointer, sp, "refused pointer");
    chk(lastAddr, prevAddr, "refused store");
    targetOk <= 1'b1;
    runOp(OP_FAR_CALL, 1'b1, rng);
    sp = bump(sp, 32'hFFFF_FFF8, 1'b0);
    chk(stack_pointer, sp, "call pointer");
    chk(32'(lastData[15:0]), 32'(rng[15:0]), "call store");
    failNext <= 1'b1;
    runOp(OP_PUSH_ERR, 1'b1, rng);
    chk(32'(sawFault), 32'h1, "fault pulse");
    chk(stack_pointer, sp, "restored pointer");
    failNext <= 1'b0;
    $display("test faults done");
    // start pulse while frozen must be lost
    @(posedge sys_clk);
    clkEn <= 1'b0;
    opCode <= OP_PUSH_SEL;
    opStart <= 1'b1;
    @(posedge sys_clk);
    opStart <= 1'b0;
    repeat (3) @(posedge sys_clk);
    clkEn <= 1'b1;
    #1;
    chk(32'(busy), 32'h0, "frozen start");
    chk(stack_pointer, sp, "frozen pointer");
    $display("test freeze done");
    for (int k = 0; k < 2; k++) begin
      rng = xs(rng);
      d = {k[0], rng[30:0]};
      runOp(OP_WRITE_CTRL, 1'b0, d);
      chk(control_word_zero, d, "control value");
      chk(32'(paging_on_flag), 32'(d[PAGING_BIT]), "paging flag");
      chk(32'(busyCycles >= SERIALIZE_CYCLES), 32'h1, "serialize");
      // near jump stand-in right after the paging change
      runOp(OP_PUSH_SEL, 1'b0, d);
    end
    $display("test control done");
    for (int k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      rng = xs(rng);
      ssDesc <= {k[0] ? 16'h0 : rng[31:16], rng, rng[15:0]};
      csDesc <= {rng, xs(rng)};
      sysDesc32 <= rng[3];
      @(negedge sys_clk);
      chk(ssBase, {ssDesc[63:56], ssDesc[39:16]}, "stack base");
      if (ssDesc[63:48] === 16'h0) chk(ssLimit, {16'h0, ssDesc[15:0]}, "byte limit");
      chk(32'(code32), 32'(csDesc[54]), "default size");
      chk(32'(gate32), 32'(sysDesc32), "gate form");
    end
    $display("test descriptors done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
